// ===== rtl/ret_cmp_bank.sv
`timescale 1ns/100ps
module ret_cmp_bank
  import ret_pkg::*;
#(
  parameter int unsigned NUM_CMP = NUM_CMP_DEFAULT
) (
  input  wire logic                           ref_clk,
  input  wire logic                           sys_rst,
  input  wire logic [TIME_W-1:0]              count,
  input  wire logic                           count_step,
  input  wire logic [NUM_CMP-1:0][TIME_W-1:0] cmp_val,
  input  wire logic [NUM_CMP-1:0]             cmp_en,
  input  wire logic [NUM_CMP-1:0]             flag_clr,
  output logic      [NUM_CMP-1:0]             match_pulse,
  output logic      [NUM_CMP-1:0]             match_flag
);

  if (NUM_CMP < 1) begin : g_chk_num_cmp
    $error("NUM_CMP must be at least one");
  end

  logic [NUM_CMP-1:0] match_now;
  logic [NUM_CMP-1:0] match_pulse_r;
  logic [NUM_CMP-1:0] match_flag_r;
  logic [NUM_CMP-1:0] match_flag_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Match only in the cycle the counter takes a new value, so a comparator
  // fires once per pass and again after a wrap
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      match_now[i] = count_step & cmp_en[i] & (count == cmp_val[i]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      match_pulse_r <= '0;
    end else begin
      match_pulse_r <= match_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a match in the clear cycle wins over the clear
  assign match_flag_nxt = (match_flag_r & ~flag_clr) | match_now;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      match_flag_r <= '0;
    end else begin
      match_flag_r <= match_flag_nxt;
    end
  end

  assign match_pulse = match_pulse_r;
  assign match_flag  = match_flag_r;

endmodule : ret_cmp_bank

// ===== rtl/ret_pkg.sv
package ret_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned REF_CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_PERIOD_NS    = 4000;
  // Least time rounds up to whole reference cycles
  localparam int unsigned PRESC_DIV_DEFAULT =
    (TICK_PERIOD_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int unsigned PRESC_W_DEFAULT   = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Counter and comparators
  localparam int unsigned TIME_W          = 24;
  localparam int unsigned BYTE_W          = 8;
  localparam int unsigned NUM_CMP_DEFAULT = 4;
  // Index of the second match comparator
  localparam int unsigned WAKE_CMP        = 1;
  localparam logic [TIME_W-1:0] TIME_RST  = 24'h00_0000;
  localparam logic [TIME_W-1:0] TIME_ONE  = 24'h00_0001;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [BYTE_W-1:0] hi;
    logic [BYTE_W-1:0] mid;
    logic [BYTE_W-1:0] lo;
  } ret_time_t;

  typedef enum logic [1:0] {
    RET_SEQ_RX,
    RET_SEQ_TX,
    RET_SEQ_CCA
  } ret_seq_t;

  typedef struct packed {
    logic     valid;
    logic     timed;
    ret_seq_t kind;
  } ret_seq_req_t;

  typedef enum logic {
    RET_ARM_IDLE,
    RET_ARM_WAIT
  } ret_arm_st_t;

  ////////////////////////////////////////////////////////////////////////////
  // Split a count into its three readable bytes
  function automatic ret_time_t ret_to_time(input logic [TIME_W-1:0] v);
    ret_time_t t;
    t.hi  = v[3*BYTE_W-1:2*BYTE_W];
    t.mid = v[2*BYTE_W-1:BYTE_W];
    t.lo  = v[BYTE_W-1:0];
    return t;
  endfunction : ret_to_time

endpackage : ret_pkg

// ===== rtl/ret_timer.sv
`timescale 1ns/100ps
// Operation
// - Tick comes from a programmable divider on the reference clock.
// - System time is a 24-bit counter advancing on every tick.
// - Counter runs uninterrupted while the modem is out of low power.
// - Current count readable as upper, middle and lower bytes.
// - Default division gives a 250 kHz tick, four microsecond steps.
// - Four compare values; equality with the counter raises an interrupt.
// - Second comparator match wakes the modem from doze.
// - Counter is captured as timestamp when frame length field arrives.
// - RX, TX or CCA may be armed to start on second comparator match.
module ret_timer
  import ret_pkg::*;
#(
  parameter int unsigned NUM_CMP   = NUM_CMP_DEFAULT,
  parameter int unsigned PRESC_W   = PRESC_W_DEFAULT,
  parameter int unsigned PRESC_DEF = PRESC_DIV_DEFAULT
) (
  input  wire logic                           ref_clk,
  input  wire logic                           sys_rst,
  input  wire logic                           timer_run,
  input  wire logic [PRESC_W-1:0]             presc_div,
  input  wire logic                           doze_mode,
  input  wire logic [NUM_CMP-1:0][TIME_W-1:0] cmp_val,
  input  wire logic [NUM_CMP-1:0]             cmp_en,
  input  wire logic [NUM_CMP-1:0]             flag_clr,
  input  wire logic                           frame_length_field,
  input  wire ret_seq_req_t                   seq_req,
  input  wire logic                           seq_abort,
  output ret_time_t                           cur_time,
  output ret_time_t                           rx_stamp,
  output logic                                rx_stamp_new,
  output logic      [NUM_CMP-1:0]             match_flag,
  output logic                                irq,
  output logic                                doze_wake,
  output logic                                seq_armed,
  output logic                                seq_start,
  output ret_seq_t                            seq_kind
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (NUM_CMP <= WAKE_CMP) begin : g_chk_num_cmp
    $error("NUM_CMP must include the second match comparator");
  end
  if (PRESC_W < 1 || PRESC_W > 16) begin : g_chk_presc_w
    $error("PRESC_W out of range");
  end
  if (PRESC_DEF >= (1 << PRESC_W)) begin : g_chk_presc_def
    $error("PRESC_DEF does not fit PRESC_W");
  end

  localparam logic [PRESC_W-1:0] PRESC_ONE = PRESC_W'(1);
  localparam logic [PRESC_W-1:0] PRESC_ZERO = '0;

  logic [PRESC_W-1:0] presc_r;
  logic [PRESC_W-1:0] presc_nxt;
  logic [PRESC_W-1:0] presc_last;
  logic               tick;
  logic [TIME_W-1:0]  count_r;
  logic [TIME_W-1:0]  count_nxt;
  logic               count_step_r;
  logic [TIME_W-1:0]  stamp_r;
  logic               stamp_new_r;
  logic [NUM_CMP-1:0] match_pulse;
  logic               wake_match;
  logic               doze_wake_r;
  ret_arm_st_t        arm_st_r;
  ret_seq_t           arm_kind_r;
  logic               seq_start_r;
  ret_seq_t           seq_kind_r;
  logic               seq_now;
  logic               seq_timed;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: divide ratio of zero or one ticks every cycle
  always_comb begin
    if (presc_div <= PRESC_ONE) begin
      presc_last = PRESC_ZERO;
    end else begin
      presc_last = presc_div - PRESC_ONE;
    end
  end

  assign tick = timer_run & (presc_r >= presc_last);

  always_comb begin
    if (!timer_run || tick) begin
      presc_nxt = PRESC_ZERO;
    end else begin
      presc_nxt = presc_r + PRESC_ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      presc_r <= PRESC_ZERO;
    end else begin
      presc_r <= presc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System time counter, wraps naturally at all ones
  assign count_nxt = count_r + TIME_ONE;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_r <= TIME_RST;
    end else if (tick) begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_step_r <= 1'b0;
    end else begin
      count_step_r <= tick;
    end
  end

  assign cur_time = ret_to_time(count_r);

  ////////////////////////////////////////////////////////////////////////////
  // Receive timestamp
  // Back-to-back strobes each take a fresh stamp
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stamp_r     <= TIME_RST;
      stamp_new_r <= 1'b0;
    end else begin
      stamp_new_r <= frame_length_field;
      if (frame_length_field) begin
        stamp_r <= count_r;
      end
    end
  end

  assign rx_stamp     = ret_to_time(stamp_r);
  assign rx_stamp_new = stamp_new_r;

  ////////////////////////////////////////////////////////////////////////////
  // Comparators
  ret_cmp_bank #(
    .NUM_CMP     (NUM_CMP)
  ) ret_cmp_bank_i (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .count       (count_r),
    .count_step  (count_step_r),
    .cmp_val     (cmp_val),
    .cmp_en      (cmp_en),
    .flag_clr    (flag_clr),
    .match_pulse (match_pulse),
    .match_flag  (match_flag)
  );

  // Interrupt is the unmasked OR of all flags
  assign irq        = |match_flag;
  assign wake_match = match_pulse[WAKE_CMP];

  ////////////////////////////////////////////////////////////////////////////
  // Doze wake-up
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      doze_wake_r <= 1'b0;
    end else begin
      doze_wake_r <= wake_match & doze_mode;
    end
  end

  assign doze_wake = doze_wake_r;

  ////////////////////////////////////////////////////////////////////////////
  // Timer-triggered sequences; a new request while armed is ignored,
  // and an abort beats a match in the same cycle
  assign seq_now   = seq_req.valid & ~seq_req.timed;
  assign seq_timed = seq_req.valid & seq_req.timed;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      arm_st_r    <= RET_ARM_IDLE;
      arm_kind_r  <= RET_SEQ_RX;
      seq_start_r <= 1'b0;
      seq_kind_r  <= RET_SEQ_RX;
    end else begin
      seq_start_r <= 1'b0;
      case (arm_st_r)
        RET_ARM_IDLE: begin
          if (seq_now) begin
            seq_start_r <= 1'b1;
            seq_kind_r  <= seq_req.kind;
          end else if (seq_timed) begin
            arm_st_r   <= RET_ARM_WAIT;
            arm_kind_r <= seq_req.kind;
          end
        end
        RET_ARM_WAIT: begin
          if (seq_abort) begin
            arm_st_r <= RET_ARM_IDLE;
          end else if (wake_match) begin
            arm_st_r    <= RET_ARM_IDLE;
            seq_start_r <= 1'b1;
            seq_kind_r  <= arm_kind_r;
          end
        end
        default: begin
          arm_st_r <= RET_ARM_IDLE;
        end
      endcase
    end
  end

  assign seq_armed = (arm_st_r == RET_ARM_WAIT);
  assign seq_start = seq_start_r;
  assign seq_kind  = seq_kind_r;

endmodule : ret_timer

// ===== test/ret_host_model.sv
`timescale 1ns/100ps
module ret_host_model
  import ret_pkg::*;
#(
  parameter int unsigned NUM_CMP = NUM_CMP_DEFAULT
) (
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire logic [NUM_CMP-1:0] match_flag,
  output logic      [NUM_CMP-1:0] flag_clr
);
  logic [3:0] age_r [NUM_CMP];

  // Slow host: clears each flag some cycles after seeing it
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NUM_CMP; i++) begin
      if (sys_rst || !match_flag[i] || flag_clr[i]) begin
        age_r[i]    <= 4'h0;
        flag_clr[i] <= 1'b0;
      end else begin
        age_r[i]    <= age_r[i] + 4'h1;
        flag_clr[i] <= (age_r[i] == 4'h7);
      end
    end
  end
endmodule : ret_host_model

// ===== test/ret_timer_monitor.sv
`timescale 1ns/100ps
module ret_timer_monitor
  import ret_pkg::*;
#(
  parameter int unsigned NUM_CMP = NUM_CMP_DEFAULT
) (
  input wire logic                           ref_clk,
  input wire logic                           sys_rst,
  input wire logic                           timer_run,
  input wire logic                           doze_mode,
  input wire logic [NUM_CMP-1:0][TIME_W-1:0] cmp_val,
  input wire logic [NUM_CMP-1:0]             cmp_en,
  input wire logic [NUM_CMP-1:0]             flag_clr,
  input wire logic                           frame_length_field,
  input wire ret_seq_req_t                   seq_req,
  input wire logic                           seq_abort,
  input wire ret_time_t                      cur_time,
  input wire ret_time_t                      rx_stamp,
  input wire logic                           rx_stamp_new,
  input wire logic [NUM_CMP-1:0]             match_flag,
  input wire logic                           irq,
  input wire logic                           doze_wake,
  input wire logic                           seq_armed,
  input wire logic                           seq_start,
  input wire ret_seq_t                       seq_kind
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_irq;
    cmp_en[NUM_CMP-1] && $changed(cur_time)
      && cur_time == cmp_val[NUM_CMP-1] |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("match did not raise irq");
  property p_step;
    $changed(cur_time) |-> cur_time == $past(cur_time) + TIME_ONE;
  endproperty
  a_step: assert property (p_step)
    else $error("count did not step by one");
  property p_hold; !timer_run |=> $stable(cur_time); endproperty
  a_hold: assert property (p_hold)
    else $error("count moved while stopped");
  property p_stamp;
    frame_length_field |=> rx_stamp_new && rx_stamp == $past(cur_time);
  endproperty
  a_stamp: assert property (p_stamp)
    else $error("timestamp wrong");
  property p_match;
    cmp_en[0] && $changed(cur_time) && cur_time == cmp_val[0]
      |=> match_flag[0];
  endproperty
  a_match: assert property (p_match)
    else $error("match flag not set");
  property p_sticky; match_flag[0] && !flag_clr[0] |=> match_flag[0];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("match flag dropped");
  property p_doze; doze_wake |-> $past(doze_mode); endproperty
  a_doze: assert property (p_doze)
    else $error("wake outside doze");
  property p_wake; doze_wake |-> match_flag[WAKE_CMP]; endproperty
  a_wake: assert property (p_wake)
    else $error("wake without match");
  property p_fire; $fell(seq_armed) && !$past(seq_abort) |-> seq_start;
  endproperty
  a_fire: assert property (p_fire)
    else $error("armed sequence left without start");
  property p_now;
    seq_req.valid && !seq_req.timed && !seq_armed
      |=> seq_start && seq_kind == $past(seq_req.kind);
  endproperty
  a_now: assert property (p_now)
    else $error("untimed start wrong");
endmodule : ret_timer_monitor

bind ret_timer ret_timer_monitor #(.NUM_CMP(NUM_CMP)) ret_timer_monitor_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .timer_run(timer_run),
  .doze_mode(doze_mode),
  .cmp_val(cmp_val), .cmp_en(cmp_en), .flag_clr(flag_clr),
  .frame_length_field(frame_length_field), .seq_req(seq_req),
  .seq_abort(seq_abort), .cur_time(cur_time), .rx_stamp(rx_stamp),
  .rx_stamp_new(rx_stamp_new), .match_flag(match_flag), .irq(irq),
  .doze_wake(doze_wake), .seq_armed(seq_armed), .seq_start(seq_start),
  .seq_kind(seq_kind));

// ===== test/test_radio_event_timer.sv
`timescale 1ns/100ps
module test_radio_event_timer;
  import ret_pkg::*;
  logic              ref_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              timer_run = 1'b0;
  logic [7:0]        presc_div = 8'h50;
  logic              doze_mode = 1'b0;
  logic [3:0][23:0]  cmp_val = '0;
  logic [3:0]        cmp_en = 4'h0;
  logic              frame_length_field = 1'b0;
  ret_seq_req_t      seq_req = '0;
  logic              seq_abort = 1'b0;
  logic [3:0]        flag_clr, match_flag;
  ret_time_t         cur_time, rx_stamp;
  logic              rx_stamp_new, irq, doze_wake, seq_armed, seq_start;
  ret_seq_t          seq_kind;
  int                n_mismatch = 0;
  int                tests_run = 0;
  int                i;
  logic [23:0]       exp;

  ret_timer ret_timer_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .timer_run(timer_run), .presc_div(presc_div), .doze_mode(doze_mode),
    .cmp_val(cmp_val), .cmp_en(cmp_en), .flag_clr(flag_clr),
    .frame_length_field(frame_length_field), .seq_req(seq_req),
    .seq_abort(seq_abort), .cur_time(cur_time), .rx_stamp(rx_stamp),
    .rx_stamp_new(rx_stamp_new), .match_flag(match_flag), .irq(irq),
    .doze_wake(doze_wake), .seq_armed(seq_armed), .seq_start(seq_start),
    .seq_kind(seq_kind));
  ret_host_model ret_host_model_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .match_flag(match_flag), .flag_clr(flag_clr));

  always #25 ref_clk = ~ref_clk;

  task chk(input logic [23:0] got, input logic [23:0] want);
    tests_run++;
    if (got !== want) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, want);
    end
  endtask : chk
  task test_done;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task lost(input int k);
    if (k >= 60) begin
      n_mismatch++;
      $display("[ERR] %0t wait ran out %h %h", $time, k, 60);
      test_done();
    end
  endtask : lost
  ////////////////////////////////////////////////////////////////////////////
  task t_count;
    exp = cur_time;
    cyc(160);
    chk(cur_time, exp + 24'h00_0002);
    presc_div = 8'h02;
    cyc(2);
    exp = cur_time;
    cyc(20);
    chk(cur_time, exp + 24'h00_000a);
    timer_run = 1'b0;
    exp = cur_time;
    cyc(6);
    chk(cur_time, exp);
    timer_run = 1'b1;
  endtask : t_count
  task t_stamp;
    frame_length_field = 1'b1;
    repeat (2) begin
      exp = cur_time;
      cyc(1);
      chk(rx_stamp_new, TIME_ONE);
      chk(rx_stamp, exp);
    end
    frame_length_field = 1'b0;
  endtask : t_stamp
  task t_match(input int k);
    cmp_val[k] = cur_time + 24'h00_0003;
    cmp_en[k] = 1'b1;
    for (i = 0; i < 60 && match_flag[k] !== 1'b1; i++) cyc(1);
    lost(i);
    chk(irq, TIME_ONE);
    cyc(4);
    chk(match_flag[k], TIME_ONE);
    for (i = 0; i < 60 && match_flag[k] !== 1'b0; i++) cyc(1);
    lost(i);
    cmp_en[k] = 1'b0;
  endtask : t_match
  task t_timed;
    doze_mode = 1'b1;
    cmp_val[1] = cur_time + 24'h00_0004;
    cmp_en[1] = 1'b1;
    seq_req = '{1'b1, 1'b1, RET_SEQ_TX};
    cyc(1);
    seq_req.valid = 1'b0;
    chk(seq_armed, TIME_ONE);
    for (i = 0; i < 60 && seq_start !== 1'b1; i++) cyc(1);
    lost(i);
    chk(doze_wake, TIME_ONE);
    chk(seq_kind, RET_SEQ_TX);
    chk(seq_armed, TIME_RST);
    doze_mode = 1'b0;
    cmp_en[1] = 1'b0;
    cyc(12);
    seq_req = '{1'b1, 1'b0, RET_SEQ_CCA};
    cyc(1);
    seq_req.valid = 1'b0;
    chk(seq_start, TIME_ONE);
    chk(seq_kind, RET_SEQ_CCA);
  endtask : t_timed
  task t_abort;
    cyc(1);
    cmp_val[1] = cur_time + 24'h00_0006;
    cmp_en[1] = 1'b1;
    seq_req = '{1'b1, 1'b1, RET_SEQ_RX};
    cyc(1);
    seq_req = '{1'b1, 1'b0, RET_SEQ_TX};
    cyc(1);
    seq_req.valid = 1'b0;
    chk(seq_start, TIME_RST);
    chk(seq_armed, TIME_ONE);
    seq_abort = 1'b1;
    cyc(1);
    seq_abort = 1'b0;
    chk(seq_armed, TIME_RST);
    repeat (20) begin
      cyc(1);
      chk(seq_start, TIME_RST);
    end
    cmp_en[1] = 1'b0;
  endtask : t_abort
  task t_reset;
    seq_req = '{1'b1, 1'b1, RET_SEQ_CCA};
    cyc(1);
    seq_req.valid = 1'b0;
    sys_rst = 1'b1;
    cyc(3);
    chk(seq_armed, TIME_RST);
    chk(seq_kind, RET_SEQ_RX);
    chk(cur_time, TIME_RST);
    chk(rx_stamp, TIME_RST);
    chk(match_flag, TIME_RST);
    sys_rst = 1'b0;
    cyc(2);
    chk(cur_time, TIME_ONE);
  endtask : t_reset

  initial begin
    cyc(12);
    sys_rst = 1'b0;
    timer_run = 1'b1;
    t_count();
    t_stamp();
    for (int k = 0; k < 4; k++) t_match(k);
    t_timed();
    t_abort();
    t_reset();
    test_done();
  end
endmodule : test_radio_event_timer
